/* pkg/ptvw_pkg.sv */
package ptvw_pkg;
  // register byte addresses
  localparam logic [11:0] ADDR_W2_TO = 12'h134;
  localparam logic [11:0] ADDR_W3_CTL = 12'h13c;
  localparam logic [11:0] ADDR_W3_BASE = 12'h140;
  localparam logic [11:0] ADDR_W3_BOUND = 12'h144;
  localparam logic [11:0] ADDR_W3_TO = 12'h148;
  localparam logic [11:0] ADDR_SPC_CTL = 12'h14c;
  // control field positions
  localparam int CTL_EN_BIT = 31;
  localparam int CTL_POST_BIT = 30;
  localparam int CTL_WIDTH_LSB = 22;
  localparam int CTL_SPACE_LSB = 16;
  localparam int CTL_PROG_BIT = 14;
  localparam int CTL_SUPER_BIT = 12;
  localparam int CTL_BLOCK_BIT = 8;
  localparam int CTL_IOSP_BIT = 0;
  localparam int SPC_IOSP_BIT = 2;
  localparam int SPC_FIELD_LSB = 0;
  localparam int ADDR_HI_LSB = 16;
  // reset values
  localparam logic [1:0] WIDTH_RESET = 2'h2;
  localparam logic SPC_IOSP_RESET = 1'b0;
  localparam logic [15:0] ADDR_HI_RESET = 16'h0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  typedef enum logic [1:0] {
    PTVW_W8 = 2'b00, PTVW_W16 = 2'b01, PTVW_W32 = 2'b10, PTVW_W64 = 2'b11
  } ptvw_width_t;

  typedef enum logic [2:0] {
    PTVW_A16 = 3'b000, PTVW_A24 = 3'b001, PTVW_A32 = 3'b010, PTVW_RSV3 = 3'b011,
    PTVW_RSV4 = 3'b100, PTVW_CSR = 3'b101, PTVW_USER1 = 3'b110, PTVW_USER2 = 3'b111
  } ptvw_space_t;

  typedef enum logic [1:0] {
    PTVW_SC_OFF = 2'b00, PTVW_SC_RMW = 2'b01, PTVW_SC_ADOH = 2'b10, PTVW_SC_RSV = 2'b11
  } ptvw_spc_t;

  typedef struct packed {
    logic enable;
    logic posted_write_enable;
    ptvw_width_t max_width_field;
    ptvw_space_t space_field;
    logic program_bit;
    logic privilege_bit;
    logic block_transfer_bit;
    logic pci_space_bit;
  } ptvw_ctl_t;

  localparam ptvw_ctl_t CTL_RESET = '{enable: 1'b0, posted_write_enable: 1'b0,
    max_width_field: ptvw_width_t'(WIDTH_RESET), space_field: PTVW_A16, program_bit: 1'b0,
    privilege_bit: 1'b0, block_transfer_bit: 1'b0, pci_space_bit: 1'b0};

  typedef struct packed {
    logic [31:0] addr;
    logic io_space;
    logic is_write;
  } ptvw_pci_req_t;

  typedef struct packed {
    logic [31:0] vme_addr;
    ptvw_space_t space;
    ptvw_width_t width;
    logic program_access;
    logic supervisor;
    logic block_ok;
    logic mblt_ok;
    logic posted;
  } ptvw_vme_req_t;
endpackage : ptvw_pkg

/* verilog/ptvw_window.sv */
`timescale 1ns/1ps
module ptvw_window
  import ptvw_pkg::*;
(
  input wire ptvw_ctl_t ctl_i,
  input wire logic [15:0] base_value_i,
  input wire logic [15:0] bound_value_i,
  input wire logic [15:0] translation_offset_i,
  input wire ptvw_pci_req_t req_i,
  output logic hit_o,
  output ptvw_vme_req_t vme_o
);
  wire [15:0] addr_hi = req_i.addr[31:16];
  wire above_base = addr_hi >= base_value_i;
  wire below_bound = (bound_value_i == 16'h0000) || (addr_hi < bound_value_i);
  wire space_match = req_i.io_space == ctl_i.pci_space_bit;
  wire a24_a32 = (ctl_i.space_field == PTVW_A24) || (ctl_i.space_field == PTVW_A32);
  wire wide64 = ctl_i.max_width_field == PTVW_W64;
  wire [15:0] vme_hi = 16'(addr_hi + translation_offset_i);

  assign hit_o = ctl_i.enable && space_match && above_base && below_bound;
  always_comb begin
    vme_o.vme_addr = {vme_hi, req_i.addr[15:0]};
    vme_o.space = ctl_i.space_field;
    vme_o.width = ctl_i.max_width_field;
    vme_o.program_access = ctl_i.program_bit;
    vme_o.supervisor = ctl_i.privilege_bit;
    vme_o.block_ok = ctl_i.block_transfer_bit && a24_a32 && !wide64;
    vme_o.mblt_ok = a24_a32 && wide64;
    vme_o.posted = req_i.is_write && ctl_i.posted_write_enable
                   && !ctl_i.pci_space_bit;
  end
endmodule : ptvw_window

/* verilog/ptvw_bridge.sv */
// Strobed register access was decided locally.
`timescale 1ns/1ps
module ptvw_bridge
  import ptvw_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic pci_valid_i,
  input wire ptvw_pci_req_t pci_req_i,
  output logic pci_claim_o,
  output ptvw_vme_req_t vme_req_o,
  output logic [1:0] spc_mode_o,
  output logic spc_io_space_o
);
  // window three control, one flop per field
  logic ctl_en;
  logic ctl_post;
  ptvw_width_t ctl_width;
  ptvw_space_t ctl_space;
  logic ctl_prog;
  logic ctl_super;
  logic ctl_block;
  logic ctl_iosp;

  // address registers keep bits 31..16 only
  logic [15:0] w2_to;
  logic [15:0] w3_base;
  logic [15:0] w3_bound;
  logic [15:0] w3_to;

  // special cycle control
  logic spc_iosp;
  ptvw_spc_t spc_field;

  logic [31:0] rdata;
  logic claim;
  ptvw_vme_req_t vme_req;
  logic [31:0] ctl_word;
  logic [31:0] spc_word;

  // register decode, selects are one-hot
  wire sel_w2_to = reg_addr_i == ADDR_W2_TO;
  wire sel_w3_ctl = reg_addr_i == ADDR_W3_CTL;
  wire sel_w3_base = reg_addr_i == ADDR_W3_BASE;
  wire sel_w3_bound = reg_addr_i == ADDR_W3_BOUND;
  wire sel_w3_to = reg_addr_i == ADDR_W3_TO;
  wire sel_spc = reg_addr_i == ADDR_SPC_CTL;
  wire sel_any = sel_w2_to || sel_w3_ctl || sel_w3_base || sel_w3_bound || sel_w3_to
                 || sel_spc;

  // write enables, unmapped writes fall through
  wire we_w2_to = reg_wr_i && sel_w2_to;
  wire we_w3_ctl = reg_wr_i && sel_w3_ctl;
  wire we_w3_base = reg_wr_i && sel_w3_base;
  wire we_w3_bound = reg_wr_i && sel_w3_bound;
  wire we_w3_to = reg_wr_i && sel_w3_to;
  wire we_spc = reg_wr_i && sel_spc;

  // next values taken from the write data
  wire next_ctl_en = reg_wdata_i[CTL_EN_BIT];
  wire next_ctl_post = reg_wdata_i[CTL_POST_BIT];
  wire ptvw_width_t next_ctl_width = ptvw_width_t'(reg_wdata_i[CTL_WIDTH_LSB +: 2]);
  wire ptvw_space_t next_ctl_space = ptvw_space_t'(reg_wdata_i[CTL_SPACE_LSB +: 3]);
  wire next_ctl_prog = reg_wdata_i[CTL_PROG_BIT];
  wire next_ctl_super = reg_wdata_i[CTL_SUPER_BIT];
  wire next_ctl_block = reg_wdata_i[CTL_BLOCK_BIT];
  wire next_ctl_iosp = reg_wdata_i[CTL_IOSP_BIT];
  wire [15:0] next_addr_hi = reg_wdata_i[ADDR_HI_LSB +: 16];
  wire next_spc_iosp = reg_wdata_i[SPC_IOSP_BIT];
  wire ptvw_spc_t next_spc_field = ptvw_spc_t'(reg_wdata_i[SPC_FIELD_LSB +: 2]);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctl_en <= CTL_RESET.enable;
    end else if (we_w3_ctl) begin
      ctl_en <= next_ctl_en;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctl_post <= CTL_RESET.posted_write_enable;
    end else if (we_w3_ctl) begin
      ctl_post <= next_ctl_post;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctl_width <= CTL_RESET.max_width_field;
    end else if (we_w3_ctl) begin
      ctl_width <= next_ctl_width;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctl_space <= CTL_RESET.space_field;
    end else if (we_w3_ctl) begin
      ctl_space <= next_ctl_space;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctl_prog <= CTL_RESET.program_bit;
    end else if (we_w3_ctl) begin
      ctl_prog <= next_ctl_prog;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctl_super <= CTL_RESET.privilege_bit;
    end else if (we_w3_ctl) begin
      ctl_super <= next_ctl_super;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctl_block <= CTL_RESET.block_transfer_bit;
    end else if (we_w3_ctl) begin
      ctl_block <= next_ctl_block;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctl_iosp <= CTL_RESET.pci_space_bit;
    end else if (we_w3_ctl) begin
      ctl_iosp <= next_ctl_iosp;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      w2_to <= ADDR_HI_RESET;
    end else if (we_w2_to) begin
      w2_to <= next_addr_hi;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      w3_base <= ADDR_HI_RESET;
    end else if (we_w3_base) begin
      w3_base <= next_addr_hi;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      w3_bound <= ADDR_HI_RESET;
    end else if (we_w3_bound) begin
      w3_bound <= next_addr_hi;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      w3_to <= ADDR_HI_RESET;
    end else if (we_w3_to) begin
      w3_to <= next_addr_hi;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      spc_iosp <= SPC_IOSP_RESET;
    end else if (we_spc) begin
      spc_iosp <= next_spc_iosp;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      spc_field <= PTVW_SC_OFF;
    end else if (we_spc) begin
      spc_field <= next_spc_field;
    end
  end

  // control fields gathered for the decoder
  wire ptvw_ctl_t w3_ctl = '{
    enable: ctl_en,
    posted_write_enable: ctl_post,
    max_width_field: ctl_width,
    space_field: ctl_space,
    program_bit: ctl_prog,
    privilege_bit: ctl_super,
    block_transfer_bit: ctl_block,
    pci_space_bit: ctl_iosp
  };

  // control word in its bit layout, reserved bits read zero
  always_comb begin
    ctl_word = UNMAPPED_READ;
    ctl_word[CTL_EN_BIT] = ctl_en;
    ctl_word[CTL_POST_BIT] = ctl_post;
    ctl_word[CTL_WIDTH_LSB +: 2] = ctl_width;
    ctl_word[CTL_SPACE_LSB +: 3] = ctl_space;
    ctl_word[CTL_PROG_BIT] = ctl_prog;
    ctl_word[CTL_SUPER_BIT] = ctl_super;
    ctl_word[CTL_BLOCK_BIT] = ctl_block;
    ctl_word[CTL_IOSP_BIT] = ctl_iosp;
  end

  always_comb begin
    spc_word = UNMAPPED_READ;
    spc_word[SPC_IOSP_BIT] = spc_iosp;
    spc_word[SPC_FIELD_LSB +: 2] = spc_field;
  end

  wire [31:0] w2_to_word = {w2_to, 16'h0000};
  wire [31:0] base_word = {w3_base, 16'h0000};
  wire [31:0] bound_word = {w3_bound, 16'h0000};
  wire [31:0] w3_to_word = {w3_to, 16'h0000};

  // and-or selection, unmapped reads return zero
  wire [31:0] mapped_word = ({32{sel_w2_to}} & w2_to_word)
                          | ({32{sel_w3_ctl}} & ctl_word)
                          | ({32{sel_w3_base}} & base_word)
                          | ({32{sel_w3_bound}} & bound_word)
                          | ({32{sel_w3_to}} & w3_to_word)
                          | ({32{sel_spc}} & spc_word);
  wire [31:0] next_rdata = sel_any ? mapped_word : UNMAPPED_READ;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata <= UNMAPPED_READ;
    end else if (reg_rd_i) begin
      rdata <= next_rdata;
    end
  end

  ptvw_window u_window3 (
    .ctl_i(w3_ctl),
    .base_value_i(w3_base),
    .bound_value_i(w3_bound),
    .translation_offset_i(w3_to),
    .req_i(pci_req_i),
    .hit_o(claim),
    .vme_o(vme_req)
  );

  // reserved mode code acts as disabled
  wire ptvw_spc_t spc_eff = (spc_field == PTVW_SC_RSV) ? PTVW_SC_OFF : spc_field;

  assign reg_rdata_o = rdata;
  assign pci_claim_o = pci_valid_i && claim;
  assign vme_req_o = vme_req;
  assign spc_mode_o = spc_eff;
  assign spc_io_space_o = spc_iosp;
endmodule : ptvw_bridge

/* test/ptvw_props.sv */
`timescale 1ns/1ps
module ptvw_props
  import ptvw_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire ptvw_pci_req_t pci_req_i,
  input wire logic pci_claim_o,
  input wire ptvw_vme_req_t vme_req_o,
  input wire logic [1:0] spc_mode_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire a2x = vme_req_o.space inside {PTVW_A24, PTVW_A32};
  rst_out_a:
    assert property ($fell(rst_i) |-> reg_rdata_o == 32'h0 && !pci_claim_o) else $error("reset");
  low_pass_a:
    assert property (pci_claim_o |-> vme_req_o.vme_addr[15:0] == pci_req_i.addr[15:0])
      else $error("low bits");
  mblt_allow_a:
    assert property (vme_req_o.mblt_ok == (a2x && vme_req_o.width == PTVW_W64)) else $error("mblt");
  block_gate_a:
    assert property (vme_req_o.block_ok |-> a2x && vme_req_o.width != PTVW_W64) else $error("blt");
  io_coupled_a:
    assert property (pci_claim_o && pci_req_i.io_space |-> !vme_req_o.posted) else $error("io");
  posted_wr_a:
    assert property (vme_req_o.posted |-> pci_req_i.is_write) else $error("posted");
  special_rsv_a:
    assert property (spc_mode_o != 2'h3) else $error("special mode");
  rdata_hold_a:
    assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("rdata");
endmodule : ptvw_props

/* test/ptvw_pci_host.sv */
`timescale 1ns/1ps
module ptvw_pci_host
  import ptvw_pkg::*;
(
  input wire logic core_clk_i,
  output logic pci_valid_o,
  output ptvw_pci_req_t pci_req_o
);
  initial begin
    pci_valid_o = 1'b0;
    pci_req_o = '0;
  end
  task automatic issue(input logic [31:0] a, input logic io, input logic w);
    @(posedge core_clk_i);
    pci_valid_o <= 1'b1;
    pci_req_o <= '{a, io, w};
  endtask : issue
endmodule : ptvw_pci_host

/* test/pci_to_vme_target_window_tb_top.sv */
`timescale 1ns/1ps
module pci_to_vme_target_window_tb_top import ptvw_pkg::*;;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] reg_addr_i = 12'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic pci_valid_i;
  logic pci_claim_o;
  logic spc_io_space_o;
  logic [1:0] spc_mode_o;
  ptvw_pci_req_t pci_req_i;
  ptvw_vme_req_t vme_req_o;
  int n_errors = 0;
  int compares = 0;
  ptvw_bridge dut (.core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .pci_valid_i, .pci_req_i, .pci_claim_o, .vme_req_o, .spc_mode_o,
    .spc_io_space_o);
  ptvw_pci_host u_pci (.core_clk_i, .pci_valid_o(pci_valid_i), .pci_req_o(pci_req_i));
  initial forever #50 core_clk_i = ~core_clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge core_clk_i);
    chk(reg_rdata_o, e);
  endtask : rd
  task automatic pr(input logic [31:0] a, input logic io, input logic w, input logic c,
    input logic [31:0] v);
    u_pci.issue(a, io, w);
    @(negedge core_clk_i);
    chk(pci_claim_o, c);
    if (c) chk(vme_req_o.vme_addr, v);
  endtask : pr
  task automatic t_reset;
    rd(ADDR_W3_CTL, 32'h0080_0000);
    rd(ADDR_W3_TO, 32'h0);
    rd(12'h100, 32'h0);
    pr(32'h0, 1'b0, 1'b0, 1'b0, 32'h0);
  endtask : t_reset
  task automatic t_decode;
    wr(ADDR_W3_BASE, 32'h1000_0000);
    wr(ADDR_W3_BOUND, 32'h2000_ffff);
    wr(ADDR_W3_TO, 32'h0100_0000);
    wr(ADDR_W3_CTL, 32'h8000_0000);
    rd(ADDR_W3_BOUND, 32'h2000_0000);
    wr(ADDR_W2_TO, 32'h5a5a_ffff);
    rd(ADDR_W2_TO, 32'h5a5a_0000);
    pr(32'h0fff_ffff, 1'b0, 1'b0, 1'b0, 32'h0);
    pr(32'h1000_0000, 1'b0, 1'b0, 1'b1, 32'h1100_0000);
    pr(32'h1fff_ffff, 1'b0, 1'b0, 1'b1, 32'h20ff_ffff);
    pr(32'h2000_0000, 1'b0, 1'b0, 1'b0, 32'h0);
    pr(32'h1000_0000, 1'b1, 1'b0, 1'b0, 32'h0);
    wr(ADDR_W3_BOUND, 32'h0);
    wr(ADDR_W3_TO, 32'hf000_0000);
    pr(32'hffff_1234, 1'b0, 1'b0, 1'b1, 32'hefff_1234);
  endtask : t_decode
  task automatic t_attr;
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_W3_CTL, 32'h80c0_0100 | (s << 16) | (s[0] << 14) | (s[1] << 12));
      pr(32'h1000_0000, 1'b0, 1'b0, 1'b1, 32'h0);
      chk({vme_req_o.space, vme_req_o.width, vme_req_o.program_access, vme_req_o.supervisor,
        vme_req_o.block_ok, vme_req_o.mblt_ok},
        {s[2:0], 2'h3, s[0], s[1], 1'b0, s == 1 || s == 2});
    end
    for (int v = 0; v < 8; v++) begin
      wr(ADDR_W3_CTL, 32'h8001_0000 | (v[2] << 8) | (v[1:0] << 22));
      pr(32'h1000_0000, 1'b0, 1'b0, 1'b1, 32'h0);
      chk({vme_req_o.width, vme_req_o.block_ok, vme_req_o.mblt_ok},
        {v[1:0], v[2] && v[1:0] != 2'h3, v[1:0] == 2'h3});
    end
  endtask : t_attr
  task automatic t_post;
    wr(ADDR_W3_CTL, 32'h8000_0000);
    pr(32'h1000_0000, 1'b0, 1'b1, 1'b1, 32'h0);
    chk(vme_req_o.posted, 1'b0);
    wr(ADDR_W3_CTL, 32'hc000_0000);
    pr(32'h1000_0000, 1'b0, 1'b1, 1'b1, 32'h0);
    chk(vme_req_o.posted, 1'b1);
    wr(ADDR_W3_CTL, 32'hc000_0001);
    pr(32'h1000_0000, 1'b0, 1'b1, 1'b0, 32'h0);
    pr(32'h1000_0000, 1'b1, 1'b1, 1'b1, 32'h0);
    chk(vme_req_o.posted, 1'b0);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_SPC_CTL, 32'h4 | c);
      @(negedge core_clk_i);
      chk({spc_io_space_o, spc_mode_o}, {1'b1, c == 3 ? 2'h0 : c[1:0]});
    end
  endtask : t_post
  task automatic test_done;
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_decode;
    t_attr;
    t_post;
    test_done;
  end
  initial begin
    #200_000;
    n_errors++;
    test_done;
  end
endmodule : pci_to_vme_target_window_tb_top
bind ptvw_bridge ptvw_props u_props (.core_clk_i, .rst_i, .reg_rd_i, .reg_rdata_o, .pci_req_i,
  .pci_claim_o, .vme_req_o, .spc_mode_o);
